/* File: cdp_pkg.sv */
package cdp_pkg;
  // Register byte offsets.
  localparam logic [7:0] CDP_CTRL_OFF = 8'h00;
  localparam logic [7:0] CDP_STAT_OFF = 8'h04;
  localparam logic [7:0] CDP_FLAG_OFF = 8'h08;
  localparam logic [7:0] CDP_EN_OFF = 8'h0c;
  // Control register field positions.
  localparam int CDP_RATIO_LSB = 0;
  localparam int CDP_RATIO_W = 3;
  localparam int CDP_SLOW_BIT = 4;
  localparam int CDP_ROI_BIT = 5;
  localparam int CDP_DOE_BIT = 6;
  localparam int CDP_HALT_BIT = 7;
  localparam int CDP_GIE_BIT = 8;
  // Control reset value and flag count.
  localparam logic [31:0] CDP_CTRL_RST = 32'h0000_0000;
  localparam int CDP_NFLAG = 8;
  // Ratio code n gives 2^(n+1) cycles per period; largest period is 256.
  localparam int CDP_CNT_W = 8;
  typedef enum logic [2:0] {
    CDP_RUN = 3'b001,
    CDP_HALT = 3'b010,
    CDP_SLEEP = 3'b100
  } cdp_state_t;
endpackage

/* File: cdp_rate_gen.sv */
`timescale 1ns/1ps
module cdp_rate_gen #(
  parameter int CNT_W = cdp_pkg::CDP_CNT_W
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Control.
  input wire logic enable,
  input wire logic [2:0] ratio,
  input wire logic restart,
  // Output.
  output logic active
);
  import cdp_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last;

  // Period minus one: 2^(ratio+1)-1.
  assign last = CNT_W'((9'h002 << ratio) - 9'h001);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (restart || !enable || cnt_q == last) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Count zero is the active cycle; the rest are idle.
  assign active = !enable || (cnt_q == '0 && !restart);
endmodule

/* File: cdp_power_ctrl.sv */
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module cdp_power_ctrl #(
  parameter int NFLAG = cdp_pkg::CDP_NFLAG
) (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // CPU core side.
  input wire logic sleep_instr,
  input wire logic return_from_irq_instr,
  input wire logic prefetch_done,
  output logic cpu_exec_en,
  output logic prog_mem_fetch_en,
  output logic irq_vector_req,
  output logic sleep_exit,
  // Interrupt sources and watchdog.
  input wire logic [NFLAG-1:0] irq_event,
  input wire logic watchdog_timeout,
  output logic watchdog_reset_req,
  output logic irq_pending,
  // Clock gates.
  input wire logic clock_output_pin_cfg_en,
  output logic system_osc_clock_en,
  output logic periph_instr_clk_en,
  output logic internal_osc_clock_en,
  output logic clock_output_pin_en,
  output logic [2:0] power_state
);
  import cdp_pkg::*;

  cdp_state_t state_q;
  logic [31:0] ctrl_q;
  logic [NFLAG-1:0] flag_q;
  logic [NFLAG-1:0] en_q;
  logic wr_q;
  logic [7:0] addr_q;
  logic [2:0] ratio_q;
  logic vec_pend_q;
  logic [NFLAG-1:0] irq_s1_q;
  logic [NFLAG-1:0] irq_s2_q;
  logic [NFLAG-1:0] irq_s3_q;
  logic wdt_s1_q;
  logic wdt_s2_q;
  logic wdt_spent_q;
  logic slow_en;
  logic recover_on_irq;
  logic slowdown_on_return;
  logic halt_sel;
  logic global_irq_enable;
  logic wake_irq;
  logic irq_rise;
  logic rate_active;
  logic restart;
  logic [NFLAG-1:0] irq_edge;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  assign slow_en = ctrl_q[CDP_SLOW_BIT];
  assign recover_on_irq = ctrl_q[CDP_ROI_BIT];
  assign slowdown_on_return = ctrl_q[CDP_DOE_BIT];
  assign halt_sel = ctrl_q[CDP_HALT_BIT];
  assign global_irq_enable = ctrl_q[CDP_GIE_BIT];

  // Synchronise sources from other domains; edges are taken after stage two.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_s1_q <= '0;
      irq_s2_q <= '0;
      irq_s3_q <= '0;
      wdt_s1_q <= 1'b0;
      wdt_s2_q <= 1'b0;
    end else begin
      irq_s1_q <= irq_event;
      irq_s2_q <= irq_s1_q;
      irq_s3_q <= irq_s2_q;
      wdt_s1_q <= watchdog_timeout;
      wdt_s2_q <= wdt_s1_q;
    end
  end

  assign irq_edge = irq_s2_q & ~irq_s3_q;
  // An enabled pending flag is a wake source even with global enable clear.
  assign wake_irq = |(flag_q & en_q);
  assign irq_pending = wake_irq;
  // Only a fresh enabled event acts on the slowdown bit.
  assign irq_rise = |(irq_edge & en_q);

  // AHB address phase capture.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end else if (hready) begin
      wr_q <= hsel && htrans[1] && hwrite;
      addr_q <= haddr[7:0];
    end
  end

  // Control register; hardware slowdown changes take priority over software.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= CDP_CTRL_RST;
    end else begin
      if (wr_q && hit(addr_q, CDP_CTRL_OFF)) begin
        ctrl_q <= {23'h000000, hwdata[8:0]};
      end
      if (irq_rise && recover_on_irq && slow_en) begin
        ctrl_q[CDP_SLOW_BIT] <= 1'b0;
      end else if (return_from_irq_instr && slowdown_on_return) begin
        ctrl_q[CDP_SLOW_BIT] <= 1'b1;
      end
    end
  end

  // Flags: hardware set beats software clear (write one to clear).
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= '0;
    end else begin
      for (int i = 0; i < NFLAG; i++) begin
        if (irq_edge[i]) begin
          flag_q[i] <= 1'b1;
        end else if (wr_q && hit(addr_q, CDP_FLAG_OFF) && hwdata[i]) begin
          flag_q[i] <= 1'b0;
        end
      end
    end
  end

  // Enables are plain storage; software must clear a flag first.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q <= '0;
    end else if (wr_q && hit(addr_q, CDP_EN_OFF)) begin
      en_q <= hwdata[NFLAG-1:0];
    end
  end

  // Power state machine.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= CDP_RUN;
    end else begin
      case (state_q)
        CDP_RUN: begin
          if (sleep_instr && !wake_irq) begin
            state_q <= halt_sel ? CDP_HALT : CDP_SLEEP;
          end
        end
        CDP_HALT: begin
          if (wake_irq || wdt_s2_q) begin
            state_q <= CDP_RUN;
          end
        end
        CDP_SLEEP: begin
          if (wake_irq || wdt_s2_q) begin
            state_q <= CDP_RUN;
          end
        end
        default: state_q <= CDP_RUN;
      endcase
    end
  end

  // Vectoring waits for the prefetched instruction to retire.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_pend_q <= 1'b0;
    end else if (irq_rise && global_irq_enable) begin
      vec_pend_q <= 1'b1;
    end else if (prefetch_done && cpu_exec_en) begin
      vec_pend_q <= 1'b0;
    end
  end

  assign irq_vector_req = vec_pend_q && prefetch_done && cpu_exec_en;

  // Restart the counter on ratio change or while out of run (halt or sleep).
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ratio_q <= 3'h0;
    end else begin
      ratio_q <= ctrl_q[CDP_RATIO_LSB +: CDP_RATIO_W];
    end
  end

  assign restart = (ratio_q != ctrl_q[CDP_RATIO_LSB +: CDP_RATIO_W]) || (state_q != CDP_RUN);

  cdp_rate_gen #(
    .CNT_W(CDP_CNT_W)
  ) u_rate (
    .hclk(hclk),
    .hresetn(hresetn),
    .enable(slow_en),
    .ratio(ctrl_q[CDP_RATIO_LSB +: CDP_RATIO_W]),
    .restart(restart),
    .active(rate_active)
  );

  // The CPU is gated; memory keeps fetching in slowdown, stops when halted.
  assign cpu_exec_en = (state_q == CDP_RUN) && rate_active;
  assign prog_mem_fetch_en = (state_q == CDP_RUN);
  assign periph_instr_clk_en = (state_q != CDP_SLEEP);
  assign system_osc_clock_en = (state_q != CDP_SLEEP);
  assign internal_osc_clock_en = 1'b1;
  assign clock_output_pin_en = clock_output_pin_cfg_en && (state_q != CDP_SLEEP);
  // A timeout that wakes the core is spent on that wake. Without this mark the timeout
  // level, still high for a few cycles after the return to run, would reset the core.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wdt_spent_q <= 1'b0;
    end else if (state_q != CDP_RUN && wdt_s2_q) begin
      wdt_spent_q <= 1'b1;
    end else if (!wdt_s2_q) begin
      wdt_spent_q <= 1'b0;
    end
  end

  // A timeout in halt only wakes; in run it resets.
  assign watchdog_reset_req = wdt_s2_q && (state_q == CDP_RUN) && !wdt_spent_q;
  assign sleep_exit = (state_q != CDP_RUN) && (wake_irq || wdt_s2_q);
  assign power_state = state_q;

  // Read data, registered in the data phase.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        CDP_CTRL_OFF: hrdata <= ctrl_q;
        CDP_STAT_OFF: hrdata <= {26'h0000000, cpu_exec_en, rate_active, vec_pend_q, state_q};
        CDP_FLAG_OFF: hrdata <= {{(32 - NFLAG){1'b0}}, flag_q};
        CDP_EN_OFF: hrdata <= {{(32 - NFLAG){1'b0}}, en_q};
        default: hrdata <= 32'h0000_0000;
      endcase
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
endmodule

/* File: cdp_cpu_model.sv */
`timescale 1ns/1ps
module cdp_cpu_model (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Core handshake.
  input wire logic cpu_exec_en,
  output logic prefetch_done
);
  // The prefetched word retires one edge after an execute cycle, never sooner.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prefetch_done <= 1'b0;
    end else begin
      prefetch_done <= cpu_exec_en;
    end
  end
endmodule

/* File: cdp_power_ctrl_asserts.sv */
`timescale 1ns/1ps
module cdp_power_ctrl_asserts
  import cdp_pkg::*;
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Core side.
  input wire logic prefetch_done,
  input wire logic cpu_exec_en,
  input wire logic prog_mem_fetch_en,
  input wire logic irq_vector_req,
  input wire logic sleep_exit,
  input wire logic watchdog_reset_req,
  // Clock gates.
  input wire logic clock_output_pin_cfg_en,
  input wire logic system_osc_clock_en,
  input wire logic periph_instr_clk_en,
  input wire logic internal_osc_clock_en,
  input wire logic clock_output_pin_en,
  input wire logic [2:0] power_state
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence halted_s;
    power_state == CDP_HALT;
  endsequence
  sequence asleep_s;
    power_state == CDP_SLEEP;
  endsequence
  halt_core_off_a: assert property (halted_s |-> !cpu_exec_en && !prog_mem_fetch_en)
    else $error("core active in halt");
  halt_clocks_on_a: assert property (halted_s |-> system_osc_clock_en && periph_instr_clk_en)
    else $error("peripheral clock stopped in halt");
  sleep_clocks_a: assert property (asleep_s |-> !system_osc_clock_en && internal_osc_clock_en)
    else $error("wrong clock gates in sleep");
  clock_output_pin_halt_a: assert property (halted_s |-> clock_output_pin_en == clock_output_pin_cfg_en)
    else $error("clock output stopped in halt");
  wdt_blocked_a: assert property (power_state != CDP_RUN |-> !watchdog_reset_req)
    else $error("watchdog reset while halted");
  wake_run_a: assert property ((halted_s or asleep_s) ##0 sleep_exit |=> power_state == CDP_RUN)
    else $error("no return to run after wake");
  fetch_on_a: assert property (power_state == CDP_RUN |-> prog_mem_fetch_en && periph_instr_clk_en)
    else $error("fetch or peripheral clock stopped in run");
  vector_order_a: assert property (irq_vector_req |-> prefetch_done && cpu_exec_en)
    else $error("vector before prefetched instruction");
endmodule
bind cdp_power_ctrl cdp_power_ctrl_asserts chk_i (.hclk(hclk), .hresetn(hresetn),
  .prefetch_done(prefetch_done), .cpu_exec_en(cpu_exec_en), .prog_mem_fetch_en(prog_mem_fetch_en),
  .irq_vector_req(irq_vector_req), .sleep_exit(sleep_exit), .watchdog_reset_req(watchdog_reset_req),
  .clock_output_pin_cfg_en(clock_output_pin_cfg_en), .system_osc_clock_en(system_osc_clock_en),
  .periph_instr_clk_en(periph_instr_clk_en), .internal_osc_clock_en(internal_osc_clock_en),
  .clock_output_pin_en(clock_output_pin_en), .power_state(power_state));

/* File: cdp_power_ctrl_test.sv */
`timescale 1ns/1ps
module cdp_power_ctrl_test;
  import cdp_pkg::*;
  logic hclk = 0, rst_n = 0, hsel = 0, hwrite = 0, slp = 0, ret = 0, wdt = 0, cfg = 1;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, rd, hrdata;
  logic [7:0] irq = 0;
  logic rdy_o, resp, ex, fetch, vec, sx, wrst, pend, sys, per, ios, co, pf;
  logic [2:0] ps;
  int n_errors = 0, cmp_count = 0, p;
  int rows [8][2] = '{'{0, 2}, '{1, 4}, '{2, 8}, '{3, 16}, '{4, 32}, '{5, 64}, '{6, 128}, '{7, 256}};
  always #4 hclk = ~hclk;
  cdp_power_ctrl uut (.hclk(hclk), .hresetn(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(rdy_o), .hrdata(hrdata),
    .hreadyout(rdy_o), .hresp(resp), .sleep_instr(slp), .return_from_irq_instr(ret),
    .prefetch_done(pf), .cpu_exec_en(ex), .prog_mem_fetch_en(fetch), .irq_vector_req(vec),
    .sleep_exit(sx), .irq_event(irq), .watchdog_timeout(wdt), .watchdog_reset_req(wrst),
    .irq_pending(pend), .clock_output_pin_cfg_en(cfg), .system_osc_clock_en(sys), .periph_instr_clk_en(per),
    .internal_osc_clock_en(ios), .clock_output_pin_en(co), .power_state(ps));
  cdp_cpu_model cpu (.hclk(hclk), .hresetn(rst_n), .cpu_exec_en(ex), .prefetch_done(pf));
  task complete_run;
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task rdy;
    int i;
    i = 0;
    @(posedge hclk);
    while (rdy_o !== 1'b1) begin
      i++;
      if (i > 50) begin
        chk({31'h0, rdy_o}, 32'h1);
        complete_run();
      end
      @(posedge hclk);
    end
  endtask
  task bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    rdy();
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    rdy();
    rd = hrdata;
  endtask
  task wait_st(input logic [2:0] s);
    for (int i = 0; i < 50 && ps !== s; i++) @(negedge hclk);
    chk({29'h0, ps}, {29'h0, s});
    if (ps !== s) complete_run();
    @(posedge hclk);
  endtask
  task gap;
    @(negedge hclk);
    for (int i = 0; i < 600 && ex !== 1'b1; i++) @(negedge hclk);
    p = 0;
    do begin
      @(negedge hclk);
      p++;
    end while (ex !== 1'b1 && p < 600);
    @(posedge hclk);
  endtask
  task pulse_sleep;
    bus(CDP_FLAG_OFF, 1'b1, 32'hff);
    slp <= 1'b1;
    @(posedge hclk);
    slp <= 1'b0;
  endtask
  task fire;
    bus(CDP_FLAG_OFF, 1'b1, 32'hff);
    irq <= 8'h01;
    repeat (4) @(posedge hclk);
    irq <= 8'h00;
    @(posedge hclk);
  endtask
  initial begin
    repeat (6) @(posedge hclk);
    rst_n <= 1'b1;
    @(negedge hclk);
    chk({29'h0, ps}, {29'h0, CDP_RUN});
    @(posedge hclk);
    bus(CDP_CTRL_OFF, 1'b0, 32'h0);
    chk(rd, CDP_CTRL_RST);
    bus(8'h10, 1'b1, 32'hff);
    bus(8'h10, 1'b0, 32'h0);
    chk(rd, 32'h0);
    for (int r = 0; r < 8; r++) begin
      bus(CDP_CTRL_OFF, 1'b1, 32'h10 | 32'(rows[r][0]));
      gap();
      chk(32'(p), 32'(rows[r][1]));
    end
    bus(CDP_EN_OFF, 1'b1, 32'h01);
    // Without recovery the slowdown survives the interrupt; with it, it clears.
    bus(CDP_CTRL_OFF, 1'b1, 32'h11);
    fire();
    bus(CDP_CTRL_OFF, 1'b0, 32'h0);
    chk(rd, 32'h11);
    bus(CDP_CTRL_OFF, 1'b1, 32'h171);
    fire();
    bus(CDP_CTRL_OFF, 1'b0, 32'h0);
    chk(rd, 32'h161);
    ret <= 1'b1;
    @(posedge hclk);
    ret <= 1'b0;
    bus(CDP_CTRL_OFF, 1'b0, 32'h0);
    chk(rd, 32'h171);
    bus(CDP_CTRL_OFF, 1'b1, 32'hb1);
    pulse_sleep();
    wait_st(CDP_HALT);
    @(negedge hclk);
    chk({27'h0, ex, fetch, sys, per, co}, 32'h7);
    @(posedge hclk);
    fire();
    wait_st(CDP_RUN);
    bus(CDP_CTRL_OFF, 1'b0, 32'h0);
    chk(rd, 32'ha1);
    bus(CDP_CTRL_OFF, 1'b1, 32'hb1);
    pulse_sleep();
    wait_st(CDP_HALT);
    wdt <= 1'b1;
    wait_st(CDP_RUN);
    wdt <= 1'b0;
    @(negedge hclk);
    chk({31'h0, wrst}, 32'h0);
    repeat (4) @(posedge hclk);
    bus(CDP_CTRL_OFF, 1'b0, 32'h0);
    chk(rd, 32'hb1);
    bus(CDP_CTRL_OFF, 1'b1, 32'h0);
    pulse_sleep();
    wait_st(CDP_SLEEP);
    @(negedge hclk);
    chk({28'h0, sys, per, ios, co}, 32'h2);
    @(posedge hclk);
    fire();
    wait_st(CDP_RUN);
    // Reset in mid-run must bring back run state and clear control.
    bus(CDP_CTRL_OFF, 1'b1, 32'h91);
    rst_n <= 1'b0;
    repeat (2) @(posedge hclk);
    rst_n <= 1'b1;
    @(negedge hclk);
    chk({28'h0, ex, ps}, {28'h0, 1'b1, CDP_RUN});
    @(posedge hclk);
    bus(CDP_CTRL_OFF, 1'b0, 32'h0);
    chk(rd, CDP_CTRL_RST);
    complete_run();
  end
endmodule
